/* octal_switch_pkg.sv */
// shared constants for the octal switch serial control block
package octal_switch_pkg;
	localparam int unsigned CLK_HZ        = 20_000_000;
	localparam int unsigned FRAME_BITS    = 16;
	localparam int unsigned CNT_W         = 5;
	localparam logic [4:0]  FRAME_LEN     = 5'h10;
	localparam logic [4:0]  CNT_MAX       = 5'h1f;
	localparam logic [7:0]  CTRL_DIAG_ONLY = 8'h00;
	localparam int unsigned NUM_CH        = 8;
	localparam int unsigned NUM_PAR       = 4;
	// two diagnostic bits per channel, channel 8 in bits 15:14
	localparam logic [1:0]  DIAG_NORMAL   = 2'h3;
	localparam logic [1:0]  DIAG_OVERLOAD = 2'h2;
	localparam logic [1:0]  DIAG_OPEN     = 2'h1;
	localparam logic [1:0]  DIAG_SHORT    = 2'h0;
	localparam logic [15:0] DIAG_RST      = 16'hffff;
	// thermal restart pattern, times in microseconds
	localparam int unsigned TICK_US       = 1;
	localparam int unsigned THERM_PERIOD_US = 1000;
	localparam int unsigned THERM_ON_US   = 100;
	localparam int unsigned TICK_CYC      = CLK_HZ / 1_000_000 * TICK_US;
	localparam logic [4:0]  TICK_LAST     = 5'(TICK_CYC - 1);
	localparam logic [9:0]  SLOT_LAST     = 10'(THERM_PERIOD_US / TICK_US - 1);
	localparam logic [9:0]  SLOT_ON       = 10'(THERM_ON_US / TICK_US);
	// bit positions in the synchronised pin vector
	localparam int unsigned SYNC_W        = 41;
	localparam int unsigned P_CS_N        = 0;
	localparam int unsigned P_SCLK        = 1;
	localparam int unsigned P_SI          = 2;
	localparam int unsigned P_RESET_N     = 3;
	localparam int unsigned P_POL         = 4;
	localparam int unsigned P_DRIVE       = 5;
	localparam int unsigned P_OVL         = 9;
	localparam int unsigned P_OVT         = 17;
	localparam int unsigned P_OPEN        = 25;
	localparam int unsigned P_SHORT       = 33;
endpackage

/* pin_sync_if.sv */
// carrier between the pin synchroniser and the control logic
`timescale 1ns/100ps
interface pin_sync_if #(parameter int unsigned W = 1);
	logic [W-1:0] raw;
	logic [W-1:0] clean;
	modport sync (input raw, output clean);
	modport user (output raw, input clean);
endinterface

/* pin_sync.sv */
// three-stage pin synchroniser with agreement of the last two stages
`timescale 1ns/100ps
module pin_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic    clk,
	input  wire logic    sys_rst,
	pin_sync_if.sync     pins
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] clean;
	} sync_state_t;

	sync_state_t s_q;
	sync_state_t s_d;

	always_comb begin
		s_d    = s_q;
		s_d.s1 = pins.raw;
		s_d.s2 = s_q.s1;
		s_d.s3 = s_q.s2;
		// a change is taken only once stages two and three agree
		s_d.clean = (~(s_q.s2 ^ s_q.s3) & s_q.s2)
			| ((s_q.s2 ^ s_q.s3) & s_q.clean);
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign pins.clean = s_q.clean;
endmodule

/* octal_switch_serial_control.sv */
// serial control, output latches and diagnosis of the octal switch
`timescale 1ns/100ps
module octal_switch_serial_control
	import octal_switch_pkg::*;
(
	input  wire logic                          clk,
	input  wire logic                          sys_rst,
	input  wire logic                          reset_n,
	input  wire logic                          cs_n,
	input  wire logic                          sclk,
	input  wire logic                          si,
	output logic                               so_o,
	output logic                               so_oe,
	input  wire logic                          input_polarity_select,
	input  wire logic                          parallel_drive_1,
	input  wire logic                          parallel_drive_2,
	input  wire logic                          parallel_drive_3,
	input  wire logic                          parallel_drive_4,
	input  wire logic [octal_switch_pkg::NUM_CH-1:0] overload_det,
	input  wire logic [octal_switch_pkg::NUM_CH-1:0] overtemp_det,
	input  wire logic [octal_switch_pkg::NUM_CH-1:0] open_load_det,
	input  wire logic [octal_switch_pkg::NUM_CH-1:0] short_gnd_det,
	output logic [octal_switch_pkg::NUM_CH-1:0]      current_limit,
	output logic                               power_channel_1,
	output logic                               power_channel_2,
	output logic                               power_channel_3,
	output logic                               power_channel_4,
	output logic                               power_channel_5,
	output logic                               power_channel_6,
	output logic                               power_channel_7,
	output logic                               power_channel_8,
	output logic                               fault_n_o,
	output logic                               fault_n_oe
);
	import octal_switch_pkg::*;

	typedef struct packed {
		logic                  sel;
		logic                  cs_prev;
		logic                  sclk_prev;
		logic [CNT_W-1:0]      cnt;
		logic [FRAME_BITS-1:0] rx;
		logic [FRAME_BITS-1:0] tx;
		logic [NUM_CH-1:0]     latch;
		logic [FRAME_BITS-1:0] diag;
		logic [NUM_CH-1:0]     outs;
		logic [NUM_CH-1:0]     climit;
		logic                  fault;
		logic                  so;
		logic [4:0]            div;
		logic [9:0]            slot;
	} ctrl_state_t;

	localparam ctrl_state_t RST_VAL = '{
		sel:       1'b0,
		cs_prev:   1'b1,
		sclk_prev: 1'b0,
		cnt:       '0,
		rx:        '0,
		tx:        '0,
		latch:     '0,
		diag:      DIAG_RST,
		outs:      '0,
		climit:    '0,
		fault:     1'b0,
		so:        1'b0,
		div:       '0,
		slot:      '0
	};

	ctrl_state_t s_q;
	ctrl_state_t s_d;

	pin_sync_if #(.W(SYNC_W)) pins ();

	assign pins.raw = {short_gnd_det, open_load_det, overtemp_det,
		overload_det, parallel_drive_4, parallel_drive_3,
		parallel_drive_2, parallel_drive_1, input_polarity_select,
		reset_n, si, sclk, cs_n};

	pin_sync #(.W(SYNC_W)) u_sync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.pins    (pins)
	);

	logic              cs_c;
	logic              sclk_c;
	logic              si_c;
	logic              rst_pin_c;
	logic              pol_c;
	logic [NUM_PAR-1:0] drive_c;
	logic [NUM_CH-1:0] ovl_c;
	logic [NUM_CH-1:0] ovt_c;
	logic [NUM_CH-1:0] open_c;
	logic [NUM_CH-1:0] short_c;

	assign cs_c      = pins.clean[P_CS_N];
	assign sclk_c    = pins.clean[P_SCLK];
	assign si_c      = pins.clean[P_SI];
	assign rst_pin_c = ~pins.clean[P_RESET_N];
	assign pol_c     = pins.clean[P_POL];
	assign drive_c   = pins.clean[P_DRIVE +: NUM_PAR];
	assign ovl_c     = pins.clean[P_OVL +: NUM_CH];
	assign ovt_c     = pins.clean[P_OVT +: NUM_CH];
	assign open_c    = pins.clean[P_OPEN +: NUM_CH];
	assign short_c   = pins.clean[P_SHORT +: NUM_CH];

	// per-channel present fault code and fault flag
	logic [FRAME_BITS-1:0] code_now;
	logic [NUM_CH-1:0]     err_now;
	logic [NUM_CH-1:0]     par_gate;

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_ch
			always_comb begin
				err_now[g] = ovl_c[g] | ovt_c[g] | open_c[g] | short_c[g];
				if (ovl_c[g] || ovt_c[g]) begin
					code_now[2*g +: 2] = DIAG_OVERLOAD;
				end else if (short_c[g]) begin
					code_now[2*g +: 2] = DIAG_SHORT;
				end else if (open_c[g]) begin
					code_now[2*g +: 2] = DIAG_OPEN;
				end else begin
					code_now[2*g +: 2] = DIAG_NORMAL;
				end
			end
			if (g < NUM_PAR) begin : g_par
				// polarity pin selects the active level of the drive
				assign par_gate[g] = ~(drive_c[g] ^ pol_c);
			end else begin : g_ser
				assign par_gate[g] = 1'b1;
			end
		end
	endgenerate

	logic cs_fall;
	logic cs_rise;
	logic sclk_fall;
	logic sclk_rise;
	logic therm_on;

	assign cs_fall   = s_q.cs_prev & ~cs_c;
	assign cs_rise   = ~s_q.cs_prev & cs_c;
	// serial clock edges count only while selected
	assign sclk_fall = s_q.sel & ~cs_c & s_q.sclk_prev & ~sclk_c;
	assign sclk_rise = s_q.sel & ~cs_c & ~s_q.sclk_prev & sclk_c;
	assign therm_on  = (s_q.slot < SLOT_ON);

	always_comb begin
		s_d           = s_q;
		s_d.cs_prev   = cs_c;
		s_d.sclk_prev = sclk_c;
		s_d.climit    = ovl_c;

		// thermal restart time base
		if (s_q.div == TICK_LAST) begin
			s_d.div = '0;
			if (s_q.slot == SLOT_LAST) begin
				s_d.slot = '0;
			end else begin
				s_d.slot = s_q.slot + 10'h001;
			end
		end else begin
			s_d.div = s_q.div + 5'h01;
		end

		// diagnosis register: a new error overwrites the old report
		for (int c = 0; c < NUM_CH; c++) begin
			if (err_now[c]) begin
				s_d.diag[2*c +: 2] = code_now[2*c +: 2];
			end else if (cs_rise) begin
				s_d.diag[2*c +: 2] = DIAG_NORMAL;
			end
		end

		if (cs_fall) begin
			s_d.sel = 1'b1;
			s_d.cnt = '0;
			s_d.rx  = '0;
			// the stored diagnosis goes out, a fault first seen in this cycle is not in it
			s_d.tx  = s_q.diag;
			s_d.so  = s_q.diag[FRAME_BITS-1];
		end else if (cs_rise) begin
			s_d.sel = 1'b0;
			if (s_q.sel && s_q.cnt == FRAME_LEN
				&& s_q.rx[15:8] != CTRL_DIAG_ONLY) begin
				s_d.latch = s_q.rx[7:0];
			end
		end else begin
			if (sclk_fall) begin
				s_d.rx = {s_q.rx[FRAME_BITS-2:0], si_c};
				if (s_q.cnt != CNT_MAX) begin
					s_d.cnt = s_q.cnt + 5'h01;
				end
			end
			// first bit is already out, later rising edges advance
			if (sclk_rise && s_q.cnt != '0) begin
				s_d.tx = {s_q.tx[FRAME_BITS-2:0], 1'b1};
				s_d.so = s_q.tx[FRAME_BITS-2];
			end
		end

		// effective outputs: latch, parallel AND and thermal pattern
		s_d.outs = s_q.latch & par_gate
			& ~(ovt_c & {NUM_CH{~therm_on}});

		s_d.fault = |err_now || (s_q.diag != DIAG_RST);

		if (rst_pin_c) begin
			// also hides the false select while the pins settle after reset
			s_d.sel   = 1'b0;
			s_d.rx    = '0;
			s_d.tx    = '0;
			s_d.cnt   = '0;
			s_d.latch = '0;
			s_d.outs  = '0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_q <= RST_VAL;
		end else begin
			s_q <= s_d;
		end
	end

	assign so_o          = s_q.so;
	assign so_oe         = s_q.sel;
	assign current_limit = s_q.climit;
	assign power_channel_1 = s_q.outs[0];
	assign power_channel_2 = s_q.outs[1];
	assign power_channel_3 = s_q.outs[2];
	assign power_channel_4 = s_q.outs[3];
	assign power_channel_5 = s_q.outs[4];
	assign power_channel_6 = s_q.outs[5];
	assign power_channel_7 = s_q.outs[6];
	assign power_channel_8 = s_q.outs[7];
	// open drain: pulls low while a fault is present or latched
	assign fault_n_o     = 1'b0;
	assign fault_n_oe    = s_q.fault;
endmodule

/* octal_switch_serial_control_asserts.sv */
// concurrent checks on the octal switch serial control ports
`timescale 1ns/100ps
module octal_switch_serial_control_asserts
	import octal_switch_pkg::*;
(
	input wire logic                      clk,
	input wire logic                      sys_rst,
	input wire logic                      reset_n,
	input wire logic                      cs_n,
	input wire logic                      so_oe,
	input wire logic                      input_polarity_select,
	input wire logic                      parallel_drive_1,
	input wire logic [octal_switch_pkg::NUM_CH-1:0] overload_det,
	input wire logic [octal_switch_pkg::NUM_CH-1:0] overtemp_det,
	input wire logic [octal_switch_pkg::NUM_CH-1:0] current_limit,
	input wire logic                      power_channel_1,
	input wire logic                      power_channel_5,
	input wire logic                      power_channel_6,
	input wire logic                      power_channel_7,
	input wire logic                      power_channel_8,
	input wire logic                      fault_n_o,
	input wire logic                      fault_n_oe
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	sequence frame_open;
		$fell(cs_n) ##1 (!cs_n && reset_n)[*7];
	endsequence
	sequence ch1_idle;
		(parallel_drive_1 != input_polarity_select)[*8];
	endsequence
	AST_SO_HIZ: assert property (cs_n[*8] |-> !so_oe)
		else $error("serial out driven while deselected");
	AST_SO_ON: assert property (frame_open |-> so_oe)
		else $error("serial out not driven while selected");
	AST_RST_OFF: assert property ((!reset_n)[*8] |->
		!power_channel_1 && !power_channel_5)
		else $error("outputs on during pin reset");
	AST_HOLD: assert property ((!cs_n && reset_n && overtemp_det == '0)[*8]
		|-> $stable({power_channel_8, power_channel_7,
		power_channel_6, power_channel_5}))
		else $error("outputs changed inside a frame");
	AST_PAR_AND: assert property (ch1_idle |-> !power_channel_1)
		else $error("channel 1 on with parallel drive inactive");
	AST_FAULT: assert property ((overload_det != '0)[*8] |-> fault_n_oe)
		else $error("fault flag missing on overload");
	AST_FAULT_LOW: assert property (fault_n_oe |-> !fault_n_o)
		else $error("fault pin driven high");
	AST_LIMIT: assert property ($stable(overload_det)[*8] |->
		current_limit == overload_det)
		else $error("current limit does not follow overload");
endmodule
bind octal_switch_serial_control octal_switch_serial_control_asserts
	i_octal_switch_serial_control_asserts (.clk, .sys_rst, .reset_n, .cs_n,
	.so_oe, .input_polarity_select, .parallel_drive_1, .overload_det,
	.overtemp_det, .current_limit, .power_channel_1, .power_channel_5,
	.power_channel_6, .power_channel_7, .power_channel_8, .fault_n_o,
	.fault_n_oe);

/* spi_master_model.sv */
// serial master model sending frames and reading diagnosis
`timescale 1ns/100ps
module spi_master_model (
	output logic      cs_n,
	output logic      sclk,
	output logic      si,
	input  wire logic so
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		si   = 1'b0;
	end
	// sel low sends the clocks with chip select left high
	task automatic xfer(input logic [15:0] tx, input int n,
		input logic sel, output logic [15:0] rx);
		rx = 16'hffff;
		cs_n = ~sel;
		#200;
		for (int i = 0; i < n; i++) begin
			#100 si = tx[15 - i % 16];
			// so holds the bit of the previous rising edge until the next
			#100 if (i > 0) rx = {rx[14:0], so};
			sclk = 1'b1;
			#200 sclk = 1'b0;
		end
		#200 rx = {rx[14:0], so};
		cs_n = 1'b1;
		si = ~si;
	endtask
endmodule

/* octal_switch_serial_control_bench.sv */
// self-checking bench for the octal switch serial control
`timescale 1ns/100ps
module octal_switch_serial_control_bench;
	import octal_switch_pkg::*;
	logic              clk = 1'b0;
	logic              sys_rst = 1'b1;
	logic              reset_n = 1'b1;
	logic              pol = 1'b1;
	logic [3:0]        drv = 4'hf;
	logic [NUM_CH-1:0] ovl = '0, ovt = '0, opn = '0, sgd = '0;
	logic [15:0]       rx;
	wire               cs_n, sclk, si, so_o, so_oe, fo, foe;
	wire [NUM_CH-1:0]  lim;
	wire [7:0]         pc;
	wire               so_w = so_oe ? so_o : 1'bz;
	int                n_errors = 0;
	int                n_compared = 0;
	int                cyc = 0;
	always #25 clk = ~clk;
	spi_master_model i_spi_master_model (.cs_n(cs_n), .sclk(sclk), .si(si),
		.so(so_w));
	octal_switch_serial_control i_octal_switch_serial_control (.clk(clk),
		.sys_rst(sys_rst), .reset_n(reset_n), .cs_n(cs_n), .sclk(sclk),
		.si(si), .so_o(so_o), .so_oe(so_oe), .input_polarity_select(pol),
		.parallel_drive_1(drv[0]), .parallel_drive_2(drv[1]),
		.parallel_drive_3(drv[2]), .parallel_drive_4(drv[3]),
		.overload_det(ovl), .overtemp_det(ovt), .open_load_det(opn),
		.short_gnd_det(sgd), .current_limit(lim), .power_channel_1(pc[0]),
		.power_channel_2(pc[1]), .power_channel_3(pc[2]),
		.power_channel_4(pc[3]), .power_channel_5(pc[4]),
		.power_channel_6(pc[5]), .power_channel_7(pc[6]),
		.power_channel_8(pc[7]), .fault_n_o(fo), .fault_n_oe(foe));
	task automatic stop_test;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic fr(input logic [15:0] tx, input int n);
		@(negedge clk);
		i_spi_master_model.xfer(tx, n, 1'b1, rx);
		wt(12);
	endtask
	task automatic t_reset;
		wt(16);
		sys_rst = 1'b0;
		wt(8);
		chk({8'h00, pc}, 16'h0000);
		chk({15'h0, so_oe}, 16'h0000);
	endtask
	task automatic t_write;
		fr(16'hffa5, 16);
		chk({8'h00, pc}, 16'h00a5);
		chk(rx, DIAG_RST);
		fr(16'h015a, 16);
		chk({8'h00, pc}, 16'h005a);
		fr(16'h00a5, 16);
		chk({8'h00, pc}, 16'h005a);
	endtask
	task automatic t_count;
		fr(16'hff0f, 15);
		chk({8'h00, pc}, 16'h005a);
		fr(16'hff0f, 17);
		chk({8'h00, pc}, 16'h005a);
		i_spi_master_model.xfer(16'hff0f, 16, 1'b0, rx);
		wt(12);
		chk({8'h00, pc}, 16'h005a);
	endtask
	task automatic t_par;
		fr(16'hffff, 16);
		drv = 4'h5;
		wt(8);
		chk({8'h00, pc}, 16'h00f5);
		pol = 1'b0;
		wt(8);
		chk({8'h00, pc}, 16'h00fa);
		pol = 1'b1;
		drv = 4'hf;
		fr(16'hfff0, 16);
		chk({8'h00, pc}, 16'h00f0);
	endtask
	task automatic t_diag;
		ovl = 8'h80;
		opn = 8'h01;
		sgd = 8'h08;
		wt(10);
		chk({8'h00, lim}, 16'h0080);
		chk({15'h0, foe}, 16'h0001);
		fr(16'h0000, 16);
		chk(rx, 16'hbf3d);
		ovl = '0;
		opn = '0;
		sgd = '0;
		fr(16'h0000, 16);
		fr(16'h0000, 16);
		chk(rx, DIAG_RST);
		chk({15'h0, foe}, 16'h0000);
	endtask
	task automatic t_therm;
		int k;
		int n_on;
		k = 0;
		n_on = 0;
		ovt = 8'h80;
		while (pc[7] !== 1'b0 && k < 25000) begin
			wt(1);
			k++;
		end
		while (pc[7] !== 1'b1 && k < 25000) begin
			wt(1);
			k++;
		end
		while (pc[7] === 1'b1 && n_on < 25000) begin
			wt(1);
			n_on++;
		end
		chk(16'(n_on), 16'(THERM_ON_US / TICK_US * TICK_CYC));
		fr(16'h0000, 16);
		chk(rx, 16'hbfff);
		ovt = '0;
	endtask
	task automatic t_rstpin;
		reset_n = 1'b0;
		wt(10);
		chk({8'h00, pc}, 16'h0000);
		reset_n = 1'b1;
		wt(10);
		chk({8'h00, pc}, 16'h0000);
		fr(16'hff81, 16);
		chk({8'h00, pc}, 16'h0081);
	endtask
	initial begin
		t_reset;
		t_write;
		t_count;
		t_par;
		t_diag;
		t_therm;
		t_rstpin;
		stop_test;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_errors++;
			stop_test;
		end
	end
endmodule
